// file: rtl/xform_defines.vh
// Shared constants for the data transform and move engine
`ifndef XFORM_DEFINES_VH
`define XFORM_DEFINES_VH
// Length operand limits and interpolation breakpoint limits
`define LEN_MIN      16'h0001
`define LEN_MAX      16'h0100
`define BP_MIN       16'h0002
`define BP_MAX       16'h0032
`define PARSE_DIGITS 4'h8
// Mode codes
`define M_PACK_HL    5'h00
`define M_PACK_LH    5'h01
`define M_SPLIT_HL   5'h02
`define M_SPLIT_LH   5'h03
`define M_HEX_HL     5'h04
`define M_HEX_LH     5'h05
`define M_ASC_HL     5'h06
`define M_ASC_LH     5'h07
`define M_NAV_FLT    5'h08
`define M_PULSE_FRQ  5'h09
`define M_RSVD_A     5'h0a
`define M_SIDEREAL   5'h0b
`define M_INTERP_16  5'h0c
`define M_INTERP_32  5'h0d
`define M_INTERP_F   5'h0e
`define M_RSVD_F     5'h0f
`define M_STR_CAT    5'h10
`define M_STR_CAP    5'h11
`define M_STR_FLT    5'h12
// Pulse frequency calculation
`define FREQ_MAX     32'h00030d40
`define MS_PER_S     32'h000003e8
`define START_MUL    32'h00000ccd
// Time conversion
`define SEC_PER_DEG  32'h000000f0
`define SEC_PER_HR   32'h00000e10
`define SEC_PER_MIN  32'h0000003c
`define SEC_PER_DAY  32'h00015180
// Fixed point 16.16 and single precision float
`define FRAC_BITS    16
`define FLT_FIX_EXP  8'h6f
`define FLT_FIX_SHR  8'h86
// Characters
`define CH_NUL       8'h00
`define CH_DOT       8'h2e
`define CH_ZERO      8'h30
`define CH_NINE      8'h39
// Sequencer states
`define ST_IDLE      4'h0
`define ST_ISSUE     4'h1
`define ST_WAIT      4'h2
`define ST_TAKE      4'h3
`define ST_WR        4'h4
`define ST_CALC      4'h5
`define ST_DIV       4'h6
`define ST_FIN       4'h7
`endif

// file: rtl/hex_nibble_codec.v
// Nibble to ASCII hex digit and ASCII hex digit to nibble converter
`timescale 1ns/1ns
`default_nettype none
module hex_nibble_codec (
	input  wire [3:0] nib_in,
	input  wire [7:0] ascii_in,
	output reg  [7:0] ascii_out,
	output reg  [3:0] nib_out
);
	// Encode: digits then upper case letters
	always @* begin
		if (nib_in < 4'ha)
			ascii_out = 8'h30 + {4'h0, nib_in};
		else
			ascii_out = 8'h37 + {4'h0, nib_in};
	end
	// Decode: digits, upper and lower case; anything else reads as zero
	always @* begin
		if (ascii_in >= 8'h30 && ascii_in <= 8'h39)
			nib_out = ascii_in[3:0];
		else if ((ascii_in >= 8'h41 && ascii_in <= 8'h46) ||
			(ascii_in >= 8'h61 && ascii_in <= 8'h66))
			nib_out = ascii_in[3:0] + 4'h9;
		else
			nib_out = 4'h0;
	end
endmodule
`default_nettype wire

// file: rtl/serial_divider.v
// Restoring serial divider, one quotient bit per clock
`timescale 1ns/1ns
`default_nettype none
module serial_divider (
	input  wire        clk,
	input  wire        reset,
	input  wire        go,
	input  wire [63:0] num,
	input  wire [31:0] den,
	output wire        done,
	output wire [31:0] quot
);
	reg  [63:0] q_reg;    // Dividend shifting out, quotient shifting in
	reg  [32:0] r_reg;    // Partial remainder
	reg  [31:0] d_reg;    // Latched divisor
	reg  [6:0]  cnt_reg;  // Bits still to produce
	reg         run_reg;  // Division in progress
	reg         done_reg; // One-cycle completion pulse
	wire [33:0] trial = {r_reg, q_reg[63]} - {2'b00, d_reg};

	assign done = done_reg;
	assign quot = q_reg[31:0];

	// A zero divisor always sets bit 31 and yields all ones when num[63:33] is zero, which callers treat as overflow
	always @(posedge clk) begin
		if (reset) begin
			q_reg    <= 64'h0;
			r_reg    <= 33'h0;
			d_reg    <= 32'h0;
			cnt_reg  <= 7'h0;
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (go) begin
				q_reg   <= num;
				r_reg   <= 33'h0;
				d_reg   <= den;
				cnt_reg <= 7'h40;
				run_reg <= 1'b1;
			end else if (run_reg) begin
				if (trial[33]) begin
					r_reg <= {r_reg[31:0], q_reg[63]};
					q_reg <= {q_reg[62:0], 1'b0};
				end else begin
					r_reg <= trial[32:0];
					q_reg <= {q_reg[62:0], 1'b1};
				end
				cnt_reg <= cnt_reg - 7'h1;
				if (cnt_reg == 7'h1) begin
					run_reg  <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/data_transform_move_engine.v
// What this block does
// - Unknown mode: no write, no error
// - Length clamped to 1 through 256
// - Modes 0/1 pack low byte pairs
// - Modes 2/3 split words into bytes
// - Mode 4 byte to hex, high first
// - Mode 5 byte to hex, low first
// - Mode 6 hex pairs to byte, high first
// - Mode 7 hex pairs to byte, low first
// - Mode 8 navigation bytes to float
// - Mode 9 pulse frequencies from five words
// - Mode 9 frequency over limit writes zero
// - Mode 9 fixes short total time first
// - Mode 11 longitude-corrected local date time
// - Mode 12 linear interpolation between breakpoints
// - Mode 12 clamps outside breakpoint range
// - Breakpoint count 2..50 else skip
// - Mode 12 interpolation truncated to 16-bit integer
// - Modes 13/14 interpolate 32-bit, float
// - Mode 16 appends source at terminator
// - Mode 16 terminates at length cap
// - Mode 17 captures string, zero word after full length
// - Mode 18 parses decimal string to float
`timescale 1ns/1ns
`default_nettype none
`include "xform_defines.vh"
module data_transform_move_engine (
	input  wire        clk,
	input  wire        reset,
	input  wire        start,
	input  wire [15:0] src_base,
	input  wire [15:0] dst_base,
	input  wire [15:0] mode,
	input  wire [15:0] len,
	output wire        busy,
	output wire        done,
	output wire        mem_rd,
	output wire        mem_wr,
	output wire [15:0] mem_addr,
	output wire [15:0] mem_wdata,
	input  wire [15:0] mem_rdata
);
	reg  [3:0]  state_reg;     // Sequencer state
	reg  [3:0]  after_reg;     // State entered when writes finish
	reg  [4:0]  mode_reg;      // Latched mode
	reg  [15:0] src_reg;       // Latched source base
	reg  [15:0] dst_reg;       // Latched destination base
	reg  [8:0]  len_reg;       // Clamped length
	reg  [8:0]  idx_reg;       // Source word or breakpoint index
	reg  [9:0]  oidx_reg;      // Destination word index
	reg  [15:0] rd_ptr_reg;    // Next read address
	reg  [2:0]  phase_reg;     // Sub-phase of multi-step modes
	reg         half_reg;      // First half of a pair held
	reg  [7:0]  hold_reg;      // Held byte or nibble
	reg  [15:0] lo_reg;        // Low word of a 32-bit item
	reg  [15:0] ibuf [0:8];    // Operand block for modes 9 and 11
	reg  [15:0] obuf [0:5];    // Words queued for writing
	reg  [2:0]  wcnt_reg;      // Number of queued words
	reg  [2:0]  wi_reg;        // Word being written
	reg  [15:0] wa_reg;        // First write address
	reg  [31:0] x_reg;         // Interpolation input
	reg  [31:0] prev_reg;      // Lower breakpoint
	reg  [31:0] s2_reg;        // Upper breakpoint
	reg  [31:0] d1_reg;        // Lower mapped value
	reg         neg_reg;       // Sign of the scaled offset
	reg  [31:0] acc_reg;       // Parsed digits
	reg  [31:0] pow_reg;       // Ten to the fraction digits
	reg         dot_reg;       // Decimal point seen
	reg  [3:0]  dig_reg;       // Digits taken
	reg         done_reg;
	reg         mem_rd_reg;
	reg         mem_wr_reg;
	reg  [15:0] mem_addr_reg;
	reg  [15:0] mem_wdata_reg;
	reg         div_go_reg;
	reg  [63:0] div_num_reg;
	reg  [31:0] div_den_reg;
	wire        div_done;
	wire [31:0] div_q;
	wire [7:0]  asc_hi;
	wire [7:0]  asc_lo;
	wire [3:0]  nib_dec;
	integer     i;

	assign busy      = (state_reg != `ST_IDLE);
	assign done      = done_reg;
	assign mem_rd    = mem_rd_reg;
	assign mem_wr    = mem_wr_reg;
	assign mem_addr  = mem_addr_reg;
	assign mem_wdata = mem_wdata_reg;

	// Signed 16.16 fixed point to single precision float
	function [31:0] fix_to_float;
		input [31:0] f;
		reg   [31:0] m;
		reg   [7:0]  p;
		integer      k;
		begin
			m = f[31] ? (32'h0 - f) : f;
			p = 8'h0;
			for (k = 0; k < 32; k = k + 1)
				if (m[k])
					p = k[7:0];
			if (p > 8'h17)
				m = m >> (p - 8'h17);
			else
				m = m << (8'h17 - p);
			if (f == 32'h0)
				fix_to_float = 32'h0;
			else
				fix_to_float = {f[31], `FLT_FIX_EXP + p, m[22:0]};
		end
	endfunction

	// Single precision float to signed 16.16 fixed point, small values flush to zero
	function [31:0] float_to_fix;
		input [31:0] f;
		reg   [31:0] m;
		begin
			m = {8'h01, f[22:0], 1'b0} >> 1;
			if (f[30:23] >= `FLT_FIX_SHR)
				m = m << (f[30:23] - `FLT_FIX_SHR);
			else
				m = m >> (`FLT_FIX_SHR - f[30:23]);
			if (f[30:23] < `FLT_FIX_EXP)
				m = 32'h0;
			float_to_fix = f[31] ? (32'h0 - m) : m;
		end
	endfunction

	// Address of item k, items taking two words in the 32-bit modes
	function [15:0] addr_of;
		input [15:0] base;
		input [8:0]  k;
		input        two;
		begin
			addr_of = base + (two ? {6'h0, k, 1'b0} : {7'h0, k});
		end
	endfunction

	// Length clamp and mode screening at launch
	wire [15:0] len_clamp = ($signed(len) < $signed(`LEN_MIN)) ? `LEN_MIN :
		($signed(len) > $signed(`LEN_MAX)) ? `LEN_MAX : len;
	wire mode_ok  = (mode <= {11'h0, `M_STR_FLT}) && (mode != {11'h0, `M_RSVD_A}) &&
		(mode != {11'h0, `M_RSVD_F});
	wire interp_in = (mode == {11'h0, `M_INTERP_16}) || (mode == {11'h0, `M_INTERP_32}) ||
		(mode == {11'h0, `M_INTERP_F});
	wire bp_bad = (len < `BP_MIN) || (len > `BP_MAX);

	// Per-word helpers
	wire [7:0]  rb   = mem_rdata[7:0];
	wire        last = ({7'h0, idx_reg} == {7'h0, len_reg} - 16'h1);
	wire        wide = (mode_reg == `M_INTERP_32) || (mode_reg == `M_INTERP_F);
	wire [31:0] raw_item = wide ? {mem_rdata, lo_reg} : {{16{mem_rdata[15]}}, mem_rdata};
	wire [31:0] item_val = (mode_reg == `M_INTERP_F) ? float_to_fix(raw_item) : raw_item;
	wire signed [63:0] prod = $signed(x_reg - prev_reg) * $signed(item_val - d1_reg);
	wire [63:0] prod_mag = prod[63] ? (64'h0 - prod) : prod;
	wire [31:0] interp_res = d1_reg + (neg_reg ? (32'h0 - div_q) : div_q);
	wire [31:0] interp_flt = fix_to_float(interp_res);
	wire [31:0] parse_flt  = fix_to_float(div_q);

	// Pulse frequency operands; the total time is stretched when ramps overrun it
	wire [16:0] ramp_sum  = {1'b0, ibuf[3]} + {1'b0, ibuf[4]};
	wire        ramp_over = ramp_sum > {1'b0, ibuf[2]};
	wire [16:0] t_eff     = ramp_over ? (ramp_sum + 17'h1) : {1'b0, ibuf[2]};
	wire [31:0] den9      = {15'h0, t_eff} - {16'h0, ramp_sum[16:1]};
	wire [63:0] num9      = {32'h0, ibuf[1], ibuf[0]} * {32'h0, `MS_PER_S};
	wire [31:0] fmax      = (div_q > `FREQ_MAX) ? 32'h0 : div_q;
	wire [63:0] fstart_w  = {32'h0, fmax} * {32'h0, `START_MUL};
	wire [31:0] fstart    = (fstart_w[47:16] > `FREQ_MAX) ? 32'h0 : fstart_w[47:16];

	// Longitude correction: four minutes of time per degree from the zone meridian
	reg signed [63:0] lon_prod;
	reg signed [31:0] tod;
	reg [15:0]        day_out;
	always @* begin
		lon_prod = $signed(float_to_fix({ibuf[1], ibuf[0]})) * $signed(`SEC_PER_DEG);
		tod = $signed({16'h0, ibuf[6]}) * $signed(`SEC_PER_HR) +
			$signed({16'h0, ibuf[7]}) * $signed(`SEC_PER_MIN) + $signed({16'h0, ibuf[8]}) +
			$signed(lon_prod[47:`FRAC_BITS]) -
			$signed({{16{ibuf[2][15]}}, ibuf[2]}) * $signed(`SEC_PER_HR);
		day_out = ibuf[5];
		if (tod < 0) begin
			tod = tod + $signed(`SEC_PER_DAY);
			day_out = ibuf[5] - 16'h1;
		end else if (tod >= $signed(`SEC_PER_DAY)) begin
			tod = tod - $signed(`SEC_PER_DAY);
			day_out = ibuf[5] + 16'h1;
		end
	end

	// Time of day split into fields; each fits a word once wrapped into one day
	wire signed [31:0] tod_hr  = tod / $signed(`SEC_PER_HR);
	wire signed [31:0] tod_min = (tod % $signed(`SEC_PER_HR)) / $signed(`SEC_PER_MIN);
	wire signed [31:0] tod_sec = tod % $signed(`SEC_PER_MIN);

	hex_nibble_codec u_codec_hi (
		.nib_in    (rb[7:4]),
		.ascii_in  (rb),
		.ascii_out (asc_hi),
		.nib_out   (nib_dec)
	);
	hex_nibble_codec u_codec_lo (
		.nib_in    (rb[3:0]),
		.ascii_in  (8'h00),
		.ascii_out (asc_lo),
		.nib_out   ()
	);
	serial_divider u_div (
		.clk   (clk),
		.reset (reset),
		.go    (div_go_reg),
		.num   (div_num_reg),
		.den   (div_den_reg),
		.done  (div_done),
		.quot  (div_q)
	);

	// Sequencer: read, wait a cycle for data, take it, queue words, write them one per cycle
	always @(posedge clk) begin
		if (reset) begin
			state_reg <= `ST_IDLE;
			after_reg <= `ST_IDLE;
			mode_reg <= 5'h0;
			src_reg <= 16'h0;
			dst_reg <= 16'h0;
			len_reg <= 9'h1;
			idx_reg <= 9'h0;
			oidx_reg <= 10'h0;
			rd_ptr_reg <= 16'h0;
			phase_reg <= 3'h0;
			half_reg <= 1'b0;
			hold_reg <= 8'h0;
			lo_reg <= 16'h0;
			wcnt_reg <= 3'h0;
			wi_reg <= 3'h0;
			wa_reg <= 16'h0;
			x_reg <= 32'h0;
			prev_reg <= 32'h0;
			s2_reg <= 32'h0;
			d1_reg <= 32'h0;
			neg_reg <= 1'b0;
			acc_reg <= 32'h0;
			pow_reg <= 32'h1;
			dot_reg <= 1'b0;
			dig_reg <= 4'h0;
			done_reg <= 1'b0;
			mem_rd_reg <= 1'b0;
			mem_wr_reg <= 1'b0;
			mem_addr_reg <= 16'h0;
			mem_wdata_reg <= 16'h0;
			div_go_reg <= 1'b0;
			div_num_reg <= 64'h0;
			div_den_reg <= 32'h0;
			for (i = 0; i < 6; i = i + 1)
				obuf[i] <= 16'h0;
		end else begin
			done_reg <= 1'b0;
			mem_rd_reg <= 1'b0;
			mem_wr_reg <= 1'b0;
			div_go_reg <= 1'b0;
			case (state_reg)
			`ST_IDLE: begin
				// Operands sampled once; start ignored while busy
				if (start) begin
					mode_reg <= mode[4:0];
					src_reg <= src_base;
					dst_reg <= dst_base;
					len_reg <= len_clamp[8:0];
					idx_reg <= 9'h0;
					oidx_reg <= 10'h0;
					phase_reg <= 3'h0;
					half_reg <= 1'b0;
					acc_reg <= 32'h0;
					pow_reg <= 32'h1;
					dot_reg <= 1'b0;
					dig_reg <= 4'h0;
					rd_ptr_reg <= (mode == {11'h0, `M_STR_CAT}) ? dst_base : src_base;
					if (!mode_ok || (interp_in && bp_bad))
						done_reg <= 1'b1;
					else
						state_reg <= `ST_ISSUE;
				end
			end
			`ST_ISSUE: begin
				mem_rd_reg <= 1'b1;
				mem_addr_reg <= rd_ptr_reg;
				state_reg <= `ST_WAIT;
			end
			`ST_WAIT: state_reg <= `ST_TAKE;
			`ST_TAKE: begin
				// Defaults: continue with the next source word
				state_reg <= `ST_ISSUE;
				rd_ptr_reg <= rd_ptr_reg + 16'h1;
				idx_reg <= idx_reg + 9'h1;
				wa_reg <= dst_reg + {6'h0, oidx_reg};
				after_reg <= last ? `ST_FIN : `ST_ISSUE;
				case (mode_reg)
				`M_PACK_HL, `M_PACK_LH, `M_ASC_HL, `M_ASC_LH: begin
					// Pairs of bytes or digits form one word; a lone last one pads with zero
					if (!half_reg && !last) begin
						hold_reg <= (mode_reg[1]) ? {4'h0, nib_dec} : rb;
						half_reg <= 1'b1;
					end else begin
						half_reg <= 1'b0;
						wcnt_reg <= 3'h1;
						oidx_reg <= oidx_reg + 10'h1;
						state_reg <= `ST_WR;
						if (!half_reg)
							obuf[0] <= (mode_reg == `M_PACK_HL) ? {rb, 8'h00} :
								(mode_reg == `M_PACK_LH) ? {8'h00, rb} :
								(mode_reg == `M_ASC_HL) ? {8'h00, nib_dec, 4'h0} :
								{8'h00, 4'h0, nib_dec};
						else if (mode_reg == `M_PACK_HL)
							obuf[0] <= {hold_reg, rb};
						else if (mode_reg == `M_PACK_LH)
							obuf[0] <= {rb, hold_reg};
						else if (mode_reg == `M_ASC_HL)
							obuf[0] <= {8'h00, hold_reg[3:0], nib_dec};
						else
							obuf[0] <= {8'h00, nib_dec, hold_reg[3:0]};
					end
				end
				`M_SPLIT_HL, `M_SPLIT_LH, `M_HEX_HL, `M_HEX_LH: begin
					// One source word yields two destination words
					wcnt_reg <= 3'h2;
					oidx_reg <= oidx_reg + 10'h2;
					state_reg <= `ST_WR;
					if (mode_reg == `M_SPLIT_HL) begin
						obuf[0] <= {8'h00, mem_rdata[15:8]};
						obuf[1] <= {8'h00, rb};
					end else if (mode_reg == `M_SPLIT_LH) begin
						obuf[0] <= {8'h00, rb};
						obuf[1] <= {8'h00, mem_rdata[15:8]};
					end else if (mode_reg == `M_HEX_HL) begin
						obuf[0] <= {8'h00, asc_hi};
						obuf[1] <= {8'h00, asc_lo};
					end else begin
						obuf[0] <= {8'h00, asc_lo};
						obuf[1] <= {8'h00, asc_hi};
					end
				end
				`M_NAV_FLT, `M_STR_FLT: begin
					// Decimal digits accumulate; the point is skipped and not counted
					if (rb == `CH_DOT && !dot_reg) begin
						dot_reg <= 1'b1;
					end else if (rb >= `CH_ZERO && rb <= `CH_NINE) begin
						acc_reg <= acc_reg * 32'ha + {28'h0, rb[3:0]};
						if (dot_reg)
							pow_reg <= pow_reg * 32'ha;
						dig_reg <= dig_reg + 4'h1;
					end
					if ((rb != `CH_DOT && (rb < `CH_ZERO || rb > `CH_NINE)) ||
						({12'h0, dig_reg} + 16'h1 >= {7'h0, len_reg} &&
						rb != `CH_DOT) || dig_reg + 4'h1 >= `PARSE_DIGITS) begin
						state_reg <= `ST_CALC;
					end
				end
				`M_PULSE_FRQ, `M_SIDEREAL: begin
					// Fixed operand block loads word by word
					ibuf[idx_reg[3:0]] <= mem_rdata;
					if (idx_reg[3:0] == ((mode_reg == `M_PULSE_FRQ) ? 4'h4 : 4'h8))
						state_reg <= `ST_CALC;
				end
				`M_INTERP_16, `M_INTERP_32, `M_INTERP_F: begin
					idx_reg <= idx_reg;
					if (wide && !half_reg) begin
						lo_reg <= mem_rdata;
						half_reg <= 1'b1;
					end else begin
						half_reg <= 1'b0;
						case (phase_reg)
						3'h0: begin
							x_reg <= item_val;
							phase_reg <= 3'h1;
							idx_reg <= 9'h1;
							rd_ptr_reg <= addr_of(src_reg, 9'h1, wide);
						end
						3'h1: begin
							// Scan for the first breakpoint at or above the input
							if ($signed(item_val) >= $signed(x_reg) && idx_reg == 9'h1) begin
								phase_reg <= 3'h3;
								rd_ptr_reg <= addr_of(dst_reg, idx_reg, wide);
							end else if ($signed(item_val) >= $signed(x_reg)) begin
								s2_reg <= item_val;
								phase_reg <= 3'h2;
								rd_ptr_reg <= addr_of(dst_reg, idx_reg - 9'h1, wide);
							end else if (idx_reg == len_reg) begin
								phase_reg <= 3'h3;
								rd_ptr_reg <= addr_of(dst_reg, idx_reg, wide);
							end else begin
								prev_reg <= item_val;
								idx_reg <= idx_reg + 9'h1;
								rd_ptr_reg <= addr_of(src_reg, idx_reg + 9'h1, wide);
							end
						end
						3'h2: begin
							d1_reg <= item_val;
							phase_reg <= 3'h4;
							rd_ptr_reg <= addr_of(dst_reg, idx_reg, wide);
						end
						3'h3: begin
							// Clamped: mapped end value copied as stored
							obuf[0] <= raw_item[15:0];
							obuf[1] <= raw_item[31:16];
							wcnt_reg <= wide ? 3'h2 : 3'h1;
							wa_reg <= dst_reg;
							after_reg <= `ST_FIN;
							state_reg <= `ST_WR;
						end
						default: begin
							// Offset times mapped span over breakpoint span
							div_num_reg <= prod_mag;
							div_den_reg <= s2_reg - prev_reg;
							neg_reg <= prod[63];
							div_go_reg <= 1'b1;
							state_reg <= `ST_DIV;
						end
						endcase
					end
				end
				`M_STR_CAT: begin
					if (phase_reg == 3'h0) begin
						// Scanning the destination for its terminator
						if (rb == `CH_NUL) begin
							phase_reg <= 3'h1;
							rd_ptr_reg <= src_reg;
						end else if (oidx_reg == {1'b0, len_reg} - 10'h1) begin
							obuf[0] <= 16'h0;
							wcnt_reg <= 3'h1;
							wa_reg <= dst_reg + {7'h0, len_reg};
							after_reg <= `ST_FIN;
							state_reg <= `ST_WR;
						end else begin
							oidx_reg <= oidx_reg + 10'h1;
						end
					end else begin
						// Appending; the cap forces a terminator at the length
						obuf[0] <= {8'h00, rb};
						obuf[1] <= 16'h0;
						wcnt_reg <= (rb != `CH_NUL &&
							oidx_reg == {1'b0, len_reg} - 10'h1) ? 3'h2 : 3'h1;
						after_reg <= (rb == `CH_NUL ||
							oidx_reg == {1'b0, len_reg} - 10'h1) ? `ST_FIN : `ST_ISSUE;
						oidx_reg <= oidx_reg + 10'h1;
						state_reg <= `ST_WR;
					end
				end
				default: begin
					// String capture; zero word follows a full-length capture
					obuf[0] <= {8'h00, rb};
					obuf[1] <= 16'h0;
					wcnt_reg <= (rb != `CH_NUL && last) ? 3'h2 : 3'h1;
					after_reg <= (rb == `CH_NUL || last) ? `ST_FIN : `ST_ISSUE;
					oidx_reg <= oidx_reg + 10'h1;
					state_reg <= `ST_WR;
				end
				endcase
			end
			`ST_CALC: begin
				if (mode_reg == `M_SIDEREAL) begin
					obuf[0] <= ibuf[3];
					obuf[1] <= ibuf[4];
					obuf[2] <= day_out;
					obuf[3] <= tod_hr[15:0];
					obuf[4] <= tod_min[15:0];
					obuf[5] <= tod_sec[15:0];
					wcnt_reg <= 3'h6;
					wa_reg <= dst_reg;
					after_reg <= `ST_FIN;
					state_reg <= `ST_WR;
				end else if (mode_reg == `M_PULSE_FRQ) begin
					div_num_reg <= num9;
					div_den_reg <= den9;
					div_go_reg <= 1'b1;
					state_reg <= `ST_DIV;
					if (ramp_over) begin
						// Total time rewritten while the divider runs
						obuf[0] <= t_eff[15:0];
						wcnt_reg <= 3'h1;
						wa_reg <= src_reg + 16'h2;
						after_reg <= `ST_DIV;
						state_reg <= `ST_WR;
					end
				end else begin
					// Fraction scaled to 16.16 before float conversion
					div_num_reg <= {16'h0, acc_reg, 16'h0};
					div_den_reg <= pow_reg;
					div_go_reg <= 1'b1;
					state_reg <= `ST_DIV;
				end
			end
			`ST_DIV: begin
				if (div_done) begin
					wa_reg <= dst_reg;
					after_reg <= `ST_FIN;
					state_reg <= `ST_WR;
					wcnt_reg <= 3'h2;
					if (mode_reg == `M_PULSE_FRQ) begin
						obuf[0] <= fmax[15:0];
						obuf[1] <= fmax[31:16];
						obuf[2] <= fstart[15:0];
						wcnt_reg <= 3'h3;
					end else if (mode_reg == `M_INTERP_16) begin
						obuf[0] <= interp_res[15:0];
						wcnt_reg <= 3'h1;
					end else if (mode_reg == `M_INTERP_32) begin
						obuf[0] <= interp_res[15:0];
						obuf[1] <= interp_res[31:16];
					end else if (mode_reg == `M_INTERP_F) begin
						obuf[0] <= interp_flt[15:0];
						obuf[1] <= interp_flt[31:16];
					end else begin
						obuf[0] <= parse_flt[15:0];
						obuf[1] <= parse_flt[31:16];
					end
				end
			end
			`ST_WR: begin
				// One word per cycle from the queue
				mem_wr_reg <= 1'b1;
				mem_addr_reg <= wa_reg + {13'h0, wi_reg};
				mem_wdata_reg <= obuf[wi_reg];
				if (wi_reg == wcnt_reg - 3'h1) begin
					wi_reg <= 3'h0;
					state_reg <= after_reg;
				end else begin
					wi_reg <= wi_reg + 3'h1;
				end
			end
			`ST_FIN: begin
				done_reg <= 1'b1;
				state_reg <= `ST_IDLE;
			end
			default: state_reg <= `ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: tb/word_memory_model.sv
// Word data memory with one-cycle read latency, the engine's far side
`timescale 1ns/1ns
`default_nettype none
module word_memory_model (
	input  wire logic        clk,
	input  wire logic        rd,
	input  wire logic        wr,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	output logic      [15:0] rdata
);
	logic [15:0] mem [0:1023]; // Word store, preset by the bench
	logic        rd_q;         // Answer cycle marker
	logic [15:0] q;            // Last word read
	// One access per edge, read data one cycle later
	always @(posedge clk) begin
		rd_q <= rd;
		if (rd)
			q <= mem[addr[9:0]];
		if (wr)
			mem[addr[9:0]] <= wdata;
	end
	// Outside the answer cycle the bus shows junk, so a late sample is caught
	assign rdata = rd_q ? q : ~q;
endmodule
`default_nettype wire

// file: tb/data_transform_move_engine_sva.sv
// Port checker for the data transform and move engine
`timescale 1ns/1ns
`default_nettype none
module data_transform_move_engine_sva (
	input wire logic        clk, reset, start, busy, done, mem_rd, mem_wr,
	input wire logic [15:0] mode, len
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	rd_wr_apart_a: assert property (!(mem_rd && mem_wr)) else $error("rd and wr together");
	done_pulse_a: assert property (done |=> !done) else $error("done too long");
	start_taken_a: assert property (start && !busy |=> busy || done) else $error("start lost");
	busy_end_a: assert property ($fell(busy) |-> done) else $error("busy fell, no done");
	bad_mode_a: assert property (start && !busy && (mode == 16'h000a || mode == 16'h000f ||
		mode > 16'h0012) |=> done && !mem_wr) else $error("unsupported mode acted");
	bp_range_a: assert property (start && !busy && mode == 16'h000c && (len < 16'h0002 ||
		len > 16'h0032) |=> done && !mem_rd) else $error("bad count ran");
	read_gap_a: assert property (mem_rd |=> !mem_rd [*2]) else $error("reads too close");
	idle_quiet_a: assert property (!busy |-> !mem_rd && !mem_wr) else $error("idle access");
endmodule
`default_nettype wire

// file: tb/data_transform_move_engine_tb.sv
// Self-checking bench for the data transform and move engine
`timescale 1ns/1ns
`default_nettype none
module data_transform_move_engine_tb;
	logic clk, reset, start, busy, done, mem_rd, mem_wr;
	logic [15:0] src_base, dst_base, mode, len, mem_addr, mem_wdata, mem_rdata;
	int failures, compares, i, j, n;
	logic [175:0] r;
	// Rows: mode, len, five source words, four expected destination words
	logic [175:0] rows [0:18] = '{
		176'h000000040012003400560078000012345678deaddead, 176'h000100040012003400560078000034127856deaddead,
		176'h00020002123456780000000000000012003400560078, 176'h00030002123456780000000000000034001200780056,
		176'h00040002001200ab0000000000000031003200410042, 176'h00050002001200ab0000000000000032003100420041,
		176'h0006000400310032006100460000001200afdeaddead, 176'h0007000400310032006100460000002100fadeaddead,
		176'h000900012710000000c800320032046a00010d05dead, 176'h0009000127100000003200320032fdee0002264cdead,
		176'h00090001ffff00ff00c800320032000000000000dead, 176'h000a000212345678000000000000deaddeaddeaddead,
		176'h000f000212345678000000000000deaddeaddeaddead, 176'h000200001234567800000000000000120034deaddead,
		176'h0002ffff1234567800000000000000120034deaddead, 176'h0011000300410042000000430000004100420000dead,
		176'h0010000200410000000000000000deaddead0000dead,
		176'h000800020031002e00350000000000003fc0deaddead, 176'h001200020031002e00350000000000003fc0deaddead};
	logic [47:0] xs = 48'h000f00050019; // Interpolation inputs
	logic [47:0] ys = 48'h0096006400c9; // Their truncated results
	data_transform_move_engine data_transform_move_engine_i (.clk(clk), .reset(reset),
		.start(start), .src_base(src_base), .dst_base(dst_base), .mode(mode), .len(len),
		.busy(busy), .done(done), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
	word_memory_model word_memory_model_i (.clk(clk), .rd(mem_rd), .wr(mem_wr),
		.addr(mem_addr), .wdata(mem_wdata), .rdata(mem_rdata));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task finish_test;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Sentinel everywhere so stray writes show up
	task fill;
		for (n = 0; n < 1024; n++)
			word_memory_model_i.mem[n] = 16'hdead;
	endtask
	// Operands stay put until done; the wait is bounded
	task run(input logic [15:0] m, input logic [15:0] l);
		mode = m;
		len = l;
		start = 1;
		@(posedge clk) #1 start = 0;
		for (n = 0; n < 5000 && done !== 1'b1; n++)
			@(posedge clk) #1;
		chk("done", 16'h0001, {15'h0, done});
		if (done !== 1'b1)
			finish_test;
		@(posedge clk) #1;
	endtask
	initial begin
		reset = 1; start = 0; src_base = 0; dst_base = 16'h0200; mode = 0; len = 1;
		failures = 0; compares = 0;
		repeat (8) @(posedge clk);
		#1 reset = 0;
		for (i = 0; i < 19; i++) begin
			r = rows[i];
			fill;
			for (j = 0; j < 5; j++)
				word_memory_model_i.mem[j] = r[143-16*j -: 16];
			run(r[175:160], r[159:144]);
			for (j = 0; j < 4; j++)
				chk("row word", r[63-16*j -: 16], word_memory_model_i.mem[512+j]);
			if (i == 9) chk("total time", 16'h0065, word_memory_model_i.mem[2]);
		end
		// Breakpoints 10 and 20 map to 100 and 201: inside, below and above
		fill;
		word_memory_model_i.mem[1] = 16'h000a; word_memory_model_i.mem[2] = 16'h0014;
		word_memory_model_i.mem[513] = 16'h0064; word_memory_model_i.mem[514] = 16'h00c9;
		for (j = 0; j < 3; j++) begin
			word_memory_model_i.mem[0] = xs[47-16*j -: 16];
			run(16'h000c, 16'h0002);
			chk("interp", ys[47-16*j -: 16], word_memory_model_i.mem[512]);
		end
		word_memory_model_i.mem[512] = 16'hdead;
		run(16'h000c, 16'h0033);
		chk("count 51", 16'hdead, word_memory_model_i.mem[512]);
		// Terminator after one letter; source 19, 0a, 14 runs into the cap of 4
		word_memory_model_i.mem[513] = 16'h0000;
		run(16'h0010, 16'h0004);
		chk("append", 16'h0019, word_memory_model_i.mem[513]);
		chk("append cap", 16'h0000, word_memory_model_i.mem[516]);
		// Reset in mid-run, then a capture whose length clamps to 256
		fill;
		mode = 16'h0011; len = 16'h012c; start = 1;
		@(posedge clk) #1 start = 0;
		repeat (20) @(posedge clk);
		#1 reset = 1;
		repeat (8) @(posedge clk);
		#1 chk("busy in reset", 16'h0000, {15'h0, busy | mem_wr});
		reset = 0;
		run(16'h0011, 16'h012c);
		chk("last copied", 16'h00ad, word_memory_model_i.mem[767]);
		chk("cap zero", 16'h0000, word_memory_model_i.mem[768]);
		chk("past cap", 16'hdead, word_memory_model_i.mem[769]);
		finish_test;
	end
endmodule
bind data_transform_move_engine data_transform_move_engine_sva data_transform_move_engine_sva_i (
	.clk(clk), .reset(reset), .start(start), .busy(busy), .done(done), .mem_rd(mem_rd),
	.mem_wr(mem_wr), .mode(mode), .len(len));
`default_nettype wire
